//--- include/squib_framer_defs.vh
// Constants for the squib driver SPI response framer.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef SQUIB_FRAMER_DEFS_VH
`define SQUIB_FRAMER_DEFS_VH

// Frame geometry
`define FRAME_BITS 5'h10
`define BIT_CNT_MAX 5'h1f
`define BIT_CNT_ZERO 5'h00
`define BIT_CNT_ONE 5'h01

// Field positions of incoming and outgoing frames
`define MODE_MSB 15
`define MODE_LSB 14
`define RW_BIT 13
`define ADDR_MSB 12
`define ADDR_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0
`define RUN_BIT 12
`define SBL_MODIFY_BIT 9
`define SBL_ENABLE_BIT 8
`define DIAG_SBL_BIT 9
`define DIAG_MOS_BIT 8
`define ARM_MSB 11
`define ARM_LSB 8
`define TX_NEXT_BIT 14

// Mode codes: responses and incoming messages
`define RESP_REGISTER 2'h0
`define RESP_COMMAND 2'h1
`define RESP_FAULT 2'h2
`define RESP_STATUS 2'h3
`define MSG_REGISTER 2'h0
`define MSG_COMMAND 2'h1
`define MSG_DIAG 2'h2
`define MSG_MONITOR 2'h3

// Reset and fill values
`define FRAME_ZERO 16'h0000
`define FAULT_FILL 14'h0000
`define BYTE_ZERO 8'h00
`define ADDR_ZERO 5'h00
`define HDR_ZERO 6'h00
`define CNT_ZERO 32'h0000_0000
`define CNT_ONE 32'h0000_0001
`define DONT_CARE_BIT 1'b0

// Timing
`define SYS_CLK_KHZ 25000
`define KHZ_PER_MHZ 1000
`define DEPLOY_SHORT_US 2000
`define DEPLOY_LONG_US 4000
`define ARM_DEGLITCH_CYCLES 8'h10
`define DEGLITCH_CNT_W 8

`endif

//--- src/input_deglitch.v
// Two-flop synchroniser followed by a stability filter for one pin.
// Assumes the pin is asynchronous to sys_clk and STABLE_CYCLES is at least 1.
`timescale 1ns/100ps

module input_deglitch #(
	parameter CNT_W = 8,
	parameter [CNT_W-1:0] STABLE_CYCLES = 16
) (
	input wire sys_clk,
	input wire rst,
	input wire pin_in,
	output reg level_out
);

	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
	localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
	localparam [CNT_W-1:0] STABLE_LAST = STABLE_CYCLES - CNT_ONE;

	reg sync1_reg;
	reg sync2_reg;
	reg [CNT_W-1:0] stable_cnt_reg;

	// First stage is read only by the second stage
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Output moves only after the new level held for the whole filter time
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stable_cnt_reg <= CNT_ZERO;
			level_out <= 1'b0;
		end else if (sync2_reg == level_out) begin
			stable_cnt_reg <= CNT_ZERO;
		end else if (stable_cnt_reg == STABLE_LAST) begin
			stable_cnt_reg <= CNT_ZERO;
			level_out <= sync2_reg;
		end else begin
			stable_cnt_reg <= stable_cnt_reg + CNT_ONE;
		end
	end

endmodule

//--- src/squib_spi_response_framer.v
// SPI frame receiver, command decoder and 16-bit response framer.
// Assumes SPI mode 0 from the host (sample on SCLK rise, shift on fall) with
// SCLK at least four sys_clk periods per phase; all pins are asynchronous.
`timescale 1ns/100ps
`include "squib_framer_defs.vh"

module squib_spi_response_framer #(
	parameter DEPLOY_SHORT_CYCLES = `DEPLOY_SHORT_US * `SYS_CLK_KHZ / `KHZ_PER_MHZ,
	parameter DEPLOY_LONG_CYCLES = `DEPLOY_LONG_US * `SYS_CLK_KHZ / `KHZ_PER_MHZ,
	parameter [`DEGLITCH_CNT_W-1:0] ARM_DEGLITCH_CYCLES = `ARM_DEGLITCH_CYCLES
) (
	input wire sys_clk,
	input wire rst,
	input wire spi_cs_n,
	input wire spi_sclk,
	input wire spi_mosi,
	output reg spi_miso,
	output wire spi_miso_oe,
	input wire deploy_enable_input,
	input wire arm_pair_zero_one,
	input wire arm_pair_two_three,
	input wire arm_pair_four_five,
	input wire arm_pair_six_seven,
	input wire [3:0] arm_stretch_active,
	input wire deploy_long_time,
	input wire [7:0] fault_report_channel_mask,
	input wire [7:0] diag_fault,
	input wire [7:0] diag_busy,
	input wire [7:0] reg_rdata,
	output reg reg_access,
	output reg reg_write,
	output reg [4:0] reg_addr,
	output reg [7:0] reg_wdata,
	output reg diag_start,
	output reg [7:0] diag_channels,
	output reg diag_sbl_test,
	output reg diag_mos_test,
	output reg sbl_enable,
	output reg [7:0] deploy_drive,
	output reg deploy_busy
);

	// Frame sequencer states, one-hot
	localparam [2:0] SEQ_IDLE = 3'h1;
	localparam [2:0] SEQ_FRAME = 3'h2;
	localparam [2:0] SEQ_EVAL = 3'h4;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg cs_s1_reg;
	reg cs_s2_reg;
	reg cs_prev_reg;
	reg sclk_s1_reg;
	reg sclk_s2_reg;
	reg sclk_prev_reg;
	reg mosi_s1_reg;
	reg mosi_s2_reg;
	reg [15:0] rx_reg;
	reg [15:0] tx_reg;
	reg [4:0] bit_cnt_reg;
	reg [1:0] resp_kind_reg;
	reg [5:0] resp_hdr_reg;
	reg [7:0] cmd_deploy_reg;
	reg [7:0] success_reg;
	reg [7:0] success_next;
	reg [7:0] success_set;
	reg [7:0] success_clr;
	reg [31:0] deploy_cnt_reg;
	reg deploy_long_reg;
	reg [15:0] response_word;
	wire [7:0] accepted_deploy;
	wire cs_fall;
	wire cs_rise;
	wire sclk_rise;
	wire sclk_fall;
	wire frame_active;
	wire frame_ok;
	wire [1:0] rx_mode;
	wire deploy_enable_level;
	wire [3:0] arm_raw;
	wire [3:0] arm_filtered;
	wire [3:0] arm_status;
	wire diag_fault_flag;
	wire diag_done_flag;
	wire [31:0] deploy_last;

	// Arming pins in bit order of the response field, 6/7 highest
	assign arm_raw = {arm_pair_six_seven, arm_pair_four_five,
		arm_pair_two_three, arm_pair_zero_one};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_arm
			input_deglitch #(
				.CNT_W(`DEGLITCH_CNT_W),
				.STABLE_CYCLES(ARM_DEGLITCH_CYCLES)
			) u_arm_filter (
				.sys_clk(sys_clk),
				.rst(rst),
				.pin_in(arm_raw[gi]),
				.level_out(arm_filtered[gi])
			);
		end
	endgenerate

	// Deploy enable shares the filter so a glitch cannot gate a deploy
	input_deglitch #(
		.CNT_W(`DEGLITCH_CNT_W),
		.STABLE_CYCLES(ARM_DEGLITCH_CYCLES)
	) u_enable_filter (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(deploy_enable_input),
		.level_out(deploy_enable_level)
	);

	// Stretch inputs exclude deploy-started stretches, so deploys never raise a flag
	assign arm_status = arm_filtered | arm_stretch_active;

	// Diagnostic summary bits
	assign diag_fault_flag = |(diag_fault & fault_report_channel_mask);
	assign diag_done_flag = ~(|diag_busy);

	// SPI pin synchronisers; only the second stage and its prev register feed any logic
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_prev_reg <= 1'b0;
			mosi_s1_reg <= 1'b0;
			mosi_s2_reg <= 1'b0;
		end else begin
			cs_s1_reg <= spi_cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_prev_reg <= cs_s2_reg;
			sclk_s1_reg <= spi_sclk;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_prev_reg <= sclk_s2_reg;
			mosi_s1_reg <= spi_mosi;
			mosi_s2_reg <= mosi_s1_reg;
		end
	end

	assign cs_fall = cs_prev_reg & ~cs_s2_reg;
	assign cs_rise = ~cs_prev_reg & cs_s2_reg;
	assign sclk_rise = ~sclk_prev_reg & sclk_s2_reg;
	assign sclk_fall = sclk_prev_reg & ~sclk_s2_reg;
	assign frame_active = ~cs_s2_reg;
	assign spi_miso_oe = frame_active;

	// Outgoing word, assembled from the kind chosen by the previous frame
	always @* begin
		response_word = `FRAME_ZERO;
		response_word[`MODE_MSB:`MODE_LSB] = resp_kind_reg;
		case (resp_kind_reg)
			`RESP_REGISTER: begin
				response_word[`RW_BIT] = resp_hdr_reg[5];
				response_word[`ADDR_MSB:`ADDR_LSB] = resp_hdr_reg[4:0];
				response_word[`DATA_MSB:`DATA_LSB] = reg_rdata;
			end
			`RESP_COMMAND: begin
				response_word[`RW_BIT] = `DONT_CARE_BIT;
				response_word[`RUN_BIT] = deploy_enable_level;
				response_word[`ARM_MSB:`ARM_LSB] = arm_status;
				response_word[`DATA_MSB:`DATA_LSB] = cmd_deploy_reg;
			end
			`RESP_FAULT: begin
				response_word[13:0] = `FAULT_FILL;
			end
			default: begin
				response_word[`RW_BIT] = diag_fault_flag;
				response_word[`RUN_BIT] = diag_done_flag;
				response_word[`ARM_MSB:`ARM_LSB] = arm_status;
				response_word[`DATA_MSB:`DATA_LSB] = success_reg;
			end
		endcase
	end

	// Shift engine: sample on SCLK rise, next bit on SCLK fall. The word is taken
	// at chip-select fall so the MSB leads the first rise; reg_rdata is read then.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_reg <= `FRAME_ZERO;
			tx_reg <= `FRAME_ZERO;
			bit_cnt_reg <= `BIT_CNT_ZERO;
			spi_miso <= 1'b0;
		end else if (cs_fall) begin
			rx_reg <= `FRAME_ZERO;
			tx_reg <= response_word;
			bit_cnt_reg <= `BIT_CNT_ZERO;
			spi_miso <= response_word[`MODE_MSB];
		end else if (frame_active) begin
			if (sclk_rise) begin
				rx_reg <= {rx_reg[14:0], mosi_s2_reg};
				if (bit_cnt_reg != `BIT_CNT_MAX) begin
					bit_cnt_reg <= bit_cnt_reg + `BIT_CNT_ONE;
				end
			end
			if (sclk_fall) begin
				tx_reg <= {tx_reg[14:0], 1'b0};
				spi_miso <= tx_reg[`TX_NEXT_BIT];
			end
		end
	end

	// Exact length and odd parity over all sixteen bits, don't-cares included
	assign frame_ok = (bit_cnt_reg == `FRAME_BITS) & (^rx_reg);
	assign rx_mode = rx_reg[`MODE_MSB:`MODE_LSB];

	// Sequencer: a frame is judged once, in the cycle after chip select rises
	always @* begin
		state_next = state_reg;
		case (state_reg)
			SEQ_IDLE: begin
				if (cs_fall) begin
					state_next = SEQ_FRAME;
				end
			end
			SEQ_FRAME: begin
				if (cs_rise) begin
					state_next = SEQ_EVAL;
				end
			end
			SEQ_EVAL: begin
				state_next = SEQ_IDLE;
			end
			default: begin
				state_next = SEQ_IDLE;
			end
		endcase
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= SEQ_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Deploy gating: enable level and earlier successes both veto a channel
	assign accepted_deploy = rx_reg[`DATA_MSB:`DATA_LSB] & ~success_reg
		& {8{deploy_enable_level}};

	assign deploy_last = (deploy_long_reg ? DEPLOY_LONG_CYCLES : DEPLOY_SHORT_CYCLES)
		- `CNT_ONE;

	// Success flag update; a set in the same cycle as a clear wins
	always @* begin
		success_set = `BYTE_ZERO;
		success_clr = `BYTE_ZERO;
		if (deploy_busy && (deploy_cnt_reg == deploy_last)) begin
			success_set = deploy_drive;
		end
		if ((state_reg == SEQ_EVAL) && !deploy_busy && frame_ok &&
			(rx_mode == `MSG_MONITOR) && rx_reg[`RUN_BIT]) begin
			success_clr = rx_reg[`DATA_MSB:`DATA_LSB];
		end
		success_next = (success_reg & ~success_clr) | success_set;
	end

	// Command decode and deployment timer. One shared timer serves all
	// channels because commands are locked out until it has finished.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			resp_kind_reg <= `RESP_STATUS;
			resp_hdr_reg <= `HDR_ZERO;
			cmd_deploy_reg <= `BYTE_ZERO;
			success_reg <= `BYTE_ZERO;
			deploy_cnt_reg <= `CNT_ZERO;
			deploy_long_reg <= 1'b0;
			deploy_drive <= `BYTE_ZERO;
			deploy_busy <= 1'b0;
			reg_access <= 1'b0;
			reg_write <= 1'b0;
			reg_addr <= `ADDR_ZERO;
			reg_wdata <= `BYTE_ZERO;
			diag_start <= 1'b0;
			diag_channels <= `BYTE_ZERO;
			diag_sbl_test <= 1'b0;
			diag_mos_test <= 1'b0;
			sbl_enable <= 1'b0;
		end else begin
			reg_access <= 1'b0;
			diag_start <= 1'b0;
			success_reg <= success_next;
			if (deploy_busy) begin
				if (deploy_cnt_reg == deploy_last) begin
					deploy_busy <= 1'b0;
					deploy_drive <= `BYTE_ZERO;
					deploy_cnt_reg <= `CNT_ZERO;
				end else begin
					deploy_cnt_reg <= deploy_cnt_reg + `CNT_ONE;
				end
			end
			if (state_reg == SEQ_EVAL) begin
				if (deploy_busy) begin
					resp_kind_reg <= `RESP_STATUS;
				end else if (!frame_ok) begin
					resp_kind_reg <= `RESP_FAULT;
				end else begin
					case (rx_mode)
						`MSG_REGISTER: begin
							resp_kind_reg <= `RESP_REGISTER;
							resp_hdr_reg <= rx_reg[`RW_BIT:`ADDR_LSB];
							reg_access <= 1'b1;
							reg_write <= rx_reg[`RW_BIT];
							reg_addr <= rx_reg[`ADDR_MSB:`ADDR_LSB];
							reg_wdata <= rx_reg[`DATA_MSB:`DATA_LSB];
						end
						`MSG_COMMAND: begin
							resp_kind_reg <= `RESP_COMMAND;
							cmd_deploy_reg <= accepted_deploy;
							if (|accepted_deploy) begin
								deploy_busy <= 1'b1;
								deploy_drive <= accepted_deploy;
								deploy_long_reg <= deploy_long_time;
								deploy_cnt_reg <= `CNT_ZERO;
							end
						end
						`MSG_DIAG: begin
							resp_kind_reg <= `RESP_STATUS;
							if (rx_reg[`RUN_BIT]) begin
								diag_start <= 1'b1;
								diag_channels <= rx_reg[`DATA_MSB:`DATA_LSB];
								diag_sbl_test <= rx_reg[`DIAG_SBL_BIT];
								diag_mos_test <= rx_reg[`DIAG_MOS_BIT];
							end
						end
						default: begin
							resp_kind_reg <= `RESP_STATUS;
							if (rx_reg[`RUN_BIT] && rx_reg[`SBL_MODIFY_BIT]) begin
								sbl_enable <= rx_reg[`SBL_ENABLE_BIT];
							end
						end
					endcase
				end
			end
		end
	end

endmodule

//--- tb/spi_host_model.sv
// Host processor acting as SPI master, mode 0, 320 ns SCLK period.
// Assumes the caller waits for the task to return before the next frame.
`timescale 1ns/100ps

module spi_host_model (
	output logic cs_n,
	output logic sclk,
	output logic mosi,
	input wire miso
);
	localparam time HALF = 160;
	logic [15:0] word;

	// Idle pins: SCLK stands still low between frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b1;
	end

	// Register frames carry R/W in bit 13, so there the caller owns parity
	task automatic xfer(input logic [15:0] tx, input logic bad, output logic [15:0] rx);
		#13;
		word = tx;
		if (tx[15:14] != 2'h0)
			word[13] = ~^{tx[15:14], tx[12:0]};
		if (bad)
			word[0] = ~word[0];
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi = word[i];
			#HALF sclk = 1'b1;
			rx[i] = miso;
			#HALF sclk = 1'b0;
		end
		#HALF cs_n = 1'b1;
		mosi = ~mosi; // Released line must not keep its last level
		#(2 * HALF);
	endtask
endmodule

//--- tb/squib_framer_properties.sv
// Checker for the squib SPI response framer, bound to its top module.
// Assumes one sys_clk domain and the deploy period parameters of the design.
`timescale 1ns/100ps

module squib_framer_checker #(
	parameter DEPLOY_SHORT_CYCLES = 50000,
	parameter DEPLOY_LONG_CYCLES = 100000
) (
	input wire sys_clk,
	input wire rst,
	input wire spi_cs_n,
	input wire spi_sclk,
	input wire spi_miso,
	input wire spi_miso_oe,
	input wire deploy_enable_input,
	input wire reg_access,
	input wire diag_start,
	input wire deploy_long_time,
	input wire [7:0] deploy_drive,
	input wire deploy_busy
);
	logic [17:0] busy_len_reg;
	logic long_seen_reg;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Length of the running deploy; a repetition could not reach these counts
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			busy_len_reg <= 18'h0_0000;
		else if (deploy_busy)
			busy_len_reg <= busy_len_reg + 18'h0_0001;
		else
			busy_len_reg <= 18'h0_0000;
	end

	// Period chosen as the deploy starts; the design latches the same input then
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			long_seen_reg <= 1'b0;
		else if (!deploy_busy)
			long_seen_reg <= deploy_long_time;
	end

	// Pin behaviour of the link and the register strobe, then the deploy sequencing
	oe_on_a: assert property ((!spi_cs_n) [*4] |-> spi_miso_oe)
		else $error("MISO not driven inside a frame");
	oe_off_a: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
		else $error("MISO driven outside a frame");
	miso_hold_a: assert property ((!spi_cs_n && spi_sclk) [*3] |-> $stable(spi_miso))
		else $error("MISO moved while SCLK high");
	access_pulse_a: assert property (reg_access |=> !reg_access)
		else $error("Register access longer than one cycle");
	busy_quiet_a: assert property (deploy_busy |-> !reg_access && !diag_start)
		else $error("Frame acted on during deploy");
	drive_hold_a: assert property (deploy_busy && $past(deploy_busy) |-> $stable(deploy_drive))
		else $error("Deploy channels changed mid deploy");
	drive_busy_a: assert property (deploy_busy == (deploy_drive != 8'h00))
		else $error("Deploy drive and busy disagree");
	deploy_len_a: assert property ($fell(deploy_busy) |->
		busy_len_reg == (long_seen_reg ? DEPLOY_LONG_CYCLES : DEPLOY_SHORT_CYCLES))
		else $error("Deploy period length wrong");
	enable_gate_a: assert property ($rose(deploy_busy) |-> $past(deploy_enable_input))
		else $error("Deploy started with enable low");

	// Main scenarios reached
	deploy_done_c: cover property ($fell(deploy_busy));
	long_deploy_c: cover property (deploy_busy && deploy_long_time);
	reg_frame_c: cover property (reg_access);
endmodule

bind squib_spi_response_framer squib_framer_checker #(
	.DEPLOY_SHORT_CYCLES(DEPLOY_SHORT_CYCLES),
	.DEPLOY_LONG_CYCLES(DEPLOY_LONG_CYCLES)
) checker_inst (.sys_clk, .rst, .spi_cs_n, .spi_sclk, .spi_miso, .spi_miso_oe,
	.deploy_enable_input, .reg_access, .diag_start, .deploy_long_time, .deploy_drive,
	.deploy_busy);

//--- tb/testbench.sv
// Self-checking bench: the host model sends frames, the bench drives the other pins.
// Assumes short deploy periods and a short de-glitch, set at the instance below.
`timescale 1ns/100ps

module testbench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic enable_pin = 1'b1;
	logic [3:0] arm_pins = 4'hc;
	logic [3:0] stretch = 4'h1;
	logic long_time = 1'b0;
	logic [7:0] mask = 8'h01;
	logic [7:0] fault = 8'h81;
	logic [7:0] dbusy = 8'h00;
	logic [7:0] rdata = 8'h5c;
	logic [15:0] pending = 16'hfd00;
	int fail_count = 0;
	int check_count = 0;
	wire cs_n, sclk, mosi, miso, miso_oe, miso_wire, reg_write, deploy_busy;
	wire [4:0] reg_addr;
	wire [7:0] reg_wdata, deploy_drive, diag_ch;
	wire sbl_test, mos_test, sbl_en;

	always #20 sys_clk = ~sys_clk;
	assign miso_wire = miso_oe ? miso : 1'bz;

	squib_spi_response_framer #(
		.DEPLOY_SHORT_CYCLES(400),
		.DEPLOY_LONG_CYCLES(800),
		.ARM_DEGLITCH_CYCLES(8'h04)
	) squib_spi_response_framer_inst (
		.sys_clk(sys_clk), .rst(rst), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
		.spi_miso(miso), .spi_miso_oe(miso_oe), .deploy_enable_input(enable_pin),
		.arm_pair_zero_one(arm_pins[0]), .arm_pair_two_three(arm_pins[1]),
		.arm_pair_four_five(arm_pins[2]), .arm_pair_six_seven(arm_pins[3]),
		.arm_stretch_active(stretch), .deploy_long_time(long_time),
		.fault_report_channel_mask(mask), .diag_fault(fault), .diag_busy(dbusy),
		.reg_rdata(rdata), .reg_access(), .reg_write(reg_write), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .diag_start(), .diag_channels(diag_ch),
		.diag_sbl_test(sbl_test), .diag_mos_test(mos_test), .sbl_enable(sbl_en),
		.deploy_drive(deploy_drive),
		.deploy_busy(deploy_busy)
	);

	spi_host_model spi_host_model_inst (
		.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso_wire)
	);

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Each frame returns the answer to the one before, so the expectation is carried over
	task automatic send(input logic [15:0] tx, input logic bad, input logic [15:0] nxt);
		logic [15:0] rx;
		spi_host_model_inst.xfer(tx, bad, rx);
		check(rx, pending);
		pending = nxt;
	endtask

	task automatic wait_idle;
		for (int n = 0; n < 1000 && deploy_busy !== 1'b0; n++)
			@(posedge sys_clk);
		check({15'h0000, deploy_busy}, 16'h0000);
	endtask

	task automatic stop_test;
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Status word fields: masked fault, completion, arm order
	task automatic t_status;
		send(16'hc000, 1'b0, 16'hcd00);
		@(posedge sys_clk);
		mask <= 8'h02;
		dbusy <= 8'h10;
		send(16'h8000, 1'b0, 16'hdd00);
		@(posedge sys_clk);
		mask <= 8'h01;
		dbusy <= 8'h00;
		fault <= 8'h00;
	endtask

	task automatic t_register;
		send(16'h2a03, 1'b0, 16'h2a5c);
		check({2'h0, reg_write, reg_addr, reg_wdata}, 16'h2a03);
		send(16'h1f00, 1'b0, 16'h1f5c);
		check({2'h0, reg_write, reg_addr, reg_wdata}, 16'h1f00);
	endtask

	task automatic t_fault;
		send(16'h40ff, 1'b1, 16'h8000);
		check({15'h0000, deploy_busy}, 16'h0000);
	endtask

	// A deploy command with enable low leaves no status and starts nothing
	task automatic t_enable_off;
		@(posedge sys_clk);
		enable_pin <= 1'b0;
		repeat (12) @(posedge sys_clk);
		send(16'h40ff, 1'b0, 16'h5d00);
		check({15'h0000, deploy_busy}, 16'h0000);
		@(posedge sys_clk);
		enable_pin <= 1'b1;
		repeat (12) @(posedge sys_clk);
	endtask

	// A clear sent during the deploy must be dropped
	task automatic t_deploy;
		send(16'h4005, 1'b0, 16'h5d05);
		check({7'h00, deploy_busy, deploy_drive}, 16'h0105);
		send(16'hd0ff, 1'b0, 16'hdd05);
		wait_idle();
		send(16'hc000, 1'b0, 16'hdd05);
	endtask

	// Set flags refuse their channels; a monitor write clears only its ones
	task automatic t_inhibit_clear;
		@(posedge sys_clk);
		long_time <= 1'b1;
		send(16'h4007, 1'b0, 16'h5d02);
		check({7'h00, deploy_busy, deploy_drive}, 16'h0102);
		wait_idle();
		send(16'hd001, 1'b0, 16'hdd06);
	endtask

	// A two-cycle glitch is filtered; a held change shows in bit 9
	task automatic t_arm_filter;
		@(posedge sys_clk);
		arm_pins <= 4'he;
		repeat (2) @(posedge sys_clk);
		arm_pins <= 4'hc;
		send(16'hc000, 1'b0, 16'hdf06);
		@(posedge sys_clk);
		arm_pins <= 4'he;
		repeat (12) @(posedge sys_clk);
		send(16'hc000, 1'b0, 16'hdf06);
		send(16'hc000, 1'b0, 16'hdf06);
	endtask

	// Diagnostic run and between-loops write latch their fields; zero bits keep flags
	task automatic t_diag_cmds;
		send(16'h92a5, 1'b0, 16'hdf06);
		check({6'h00, sbl_test, mos_test, diag_ch}, 16'h02a5);
		send(16'hd300, 1'b0, 16'hdf06);
		check({15'h0000, sbl_en}, 16'h0001);
		send(16'hc000, 1'b0, 16'hdf06);
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (20) @(posedge sys_clk);
		t_status();
		t_register();
		t_fault();
		t_enable_off();
		t_deploy();
		t_inhibit_clear();
		t_arm_filter();
		t_diag_cmds();
		stop_test();
	end

	// Cuts a hang short; the whole sequence needs well under half of this
	initial begin
		#1_000_000;
		fail_count++;
		stop_test();
	end
endmodule
